// ---- hdl/obx_exec.sv ----
// execution unit for trap, or, secondary page transfer, long jump and long call
`timescale 1ns/1ps
`default_nettype none
module obx_exec
   import obx_pkg::*;
#(
   parameter int STACK_DEPTH = OBX_STACK_DEPTH
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic resetn_i,
   // instruction from decode
   input wire logic instr_valid_i,
   input wire obx_op_t instr_op_i,
   input wire logic [7:0] instr_imm_i,
   input wire logic [10:0] instr_target_i,
   input wire logic [6:0] instr_reg_i,
   input wire logic instr_dest_i,
   input wire logic [3:0] instr_sec_i,
   input wire logic skip_i,
   // data register file
   input wire logic [7:0] reg_rdata_i,
   output logic [6:0] reg_addr_o,
   output logic reg_we_o,
   output logic [7:0] reg_wdata_o,
   // secondary page registers
   input wire logic [7:0] sec_rdata_i,
   output logic [3:0] sec_addr_o,
   output logic sec_we_o,
   output logic [7:0] sec_wdata_o,
   // core state
   output logic [10:0] pc_o,
   output logic [7:0] accumulator_o,
   output logic zero_o,
   output logic [$clog2(STACK_DEPTH)-1:0] stack_level_o,
   output logic [10:0] stack_top_o,
   output logic busy_o
);
   // width of the stack level; the level wraps after STACK_DEPTH pushes
   // STACK_DEPTH must be a power of two for that wrap to match the depth
   localparam int LW = $clog2(STACK_DEPTH);

   // unit state except the stack entries in one word: control, core registers and pending write-backs
   typedef struct packed {
      obx_state_t st;
      logic [10:0] pc;
      logic [10:0] target;
      logic [7:0] acc;
      logic zero;
      logic [LW-1:0] lvl;
      logic stk_used; // set by the first push, keeps the top valid after a wrap
      logic [6:0] raddr;
      logic rwe;
      logic [7:0] rdata;
      logic [3:0] saddr;
      logic swe;
      logic [7:0] sdata;
   } obx_regs_t;

   // registered state and its next value
   obx_regs_t s_q, s_d;

   // return stack entries; only written, never cleared by reset
   logic [10:0] stack_q [STACK_DEPTH];

   // push strobe and the return address that goes with it
   logic push;
   logic [10:0] push_addr;

   // shared result of both or forms, feeds the zero flag as well
   logic [7:0] or_res;

   // combined next-state for one instruction step
   // an instruction is taken only in the execute state; during the wait states
   // of trap, long jump and long call the decode inputs are ignored, skip too.
   // the register file and the secondary page each share one address port
   // between the read of the next instruction and the write-back of the
   // previous one, so the instruction after a write-back must not read that
   // file: one address port per file was traded for this ordering limit.
   // the decode path is expected to keep that slot free
   always_comb begin
      // hold everything by default; write strobes are single-cycle pulses
      s_d = s_q;
      s_d.rwe = 1'b0;
      s_d.swe = 1'b0;
      push = 1'b0;
      push_addr = s_q.pc + 11'h001;
      or_res = 8'h00;
      // three-state sequencer: execute, then up to two wait cycles
      unique case (s_q.st)
         OBX_ST_EXEC: begin
            if (skip_i) begin
               // (RULE10) fetched word dropped
               // it runs as a no-operation: no data, flag or stack change
               s_d.pc = s_q.pc + 11'h001;
            end else if (instr_valid_i) begin
               // every code of the opcode is a legal operation, hence no default
               unique case (instr_op_i)
                  OBX_OP_TRAP: begin
                     // (RULE1) push return address
                     push = 1'b1;
                     // (RULE2) vector after two waits
                     // the vector sits in target so all branches share one load path
                     s_d.target = OBX_TRAP_VECTOR;
                     s_d.st = OBX_ST_WAIT2;
                  end
                  OBX_OP_OR_IMM: begin
                     // (RULE3) or with constant
                     or_res = s_q.acc | instr_imm_i;
                     s_d.acc = or_res;
                     // (RULE11) zero from result
                     s_d.zero = obx_is_zero(or_res);
                     s_d.pc = s_q.pc + 11'h001;
                  end
                  OBX_OP_OR_REG: begin
                     // (RULE4) or with register
                     or_res = s_q.acc | reg_rdata_i;
                     // register result is written one cycle later, accumulator kept
                     if (instr_dest_i) begin
                        s_d.rwe = 1'b1;
                        s_d.raddr = instr_reg_i;
                        s_d.rdata = or_res;
                     end else begin
                        s_d.acc = or_res;
                     end
                     // (RULE11) zero from result
                     s_d.zero = obx_is_zero(or_res);
                     s_d.pc = s_q.pc + 11'h001;
                  end
                  OBX_OP_STORE_SEC: begin
                     // (RULE5) out-of-range select is ignored
                     if (instr_sec_i >= OBX_SEC_LOW && instr_sec_i <= OBX_SEC_HIGH) begin
                        s_d.swe = 1'b1;
                        s_d.saddr = instr_sec_i;
                        s_d.sdata = s_q.acc;
                     end
                     s_d.pc = s_q.pc + 11'h001;
                  end
                  OBX_OP_LOAD_SEC: begin
                     // (RULE6) copy into accumulator
                     // zero flag is left alone on purpose
                     s_d.acc = sec_rdata_i;
                     s_d.pc = s_q.pc + 11'h001;
                  end
                  OBX_OP_LJUMP: begin
                     // (RULE7) jump after one wait
                     // target captured now; decode inputs may change during the wait
                     s_d.target = instr_target_i;
                     s_d.st = OBX_ST_WAIT1;
                  end
                  OBX_OP_LONG_CALL_OP: begin
                     // (RULE8) push then jump
                     // return address is pc plus one, pushed in the taking cycle
                     push = 1'b1;
                     s_d.target = instr_target_i;
                     s_d.st = OBX_ST_WAIT1;
                  end
                  // plain no-operation still walks on
                  OBX_OP_NONE: s_d.pc = s_q.pc + 11'h001;
               endcase
            end
         end
         // (RULE2) extra cycle only the trap spends
         OBX_ST_WAIT2: s_d.st = OBX_ST_WAIT1;
         // last cycle of trap, jump and call: the new address lands here
         OBX_ST_WAIT1: begin
            s_d.pc = s_q.target;
            s_d.st = OBX_ST_EXEC;
         end
         // unused state code falls back to execute
         default: s_d.st = OBX_ST_EXEC;
      endcase
      // (RULE9) level advances after write
      if (push) begin
         s_d.lvl = s_q.lvl + LW'(1);
         s_d.stk_used = 1'b1;
      end
   end

   // state register; stack wraps at its depth, as the small core does
   // the reset branch loads constants only; the release is taken as synchronous
   always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s_q <= '{st: OBX_ST_EXEC, pc: OBX_PC_RESET, target: OBX_PC_RESET,
                  acc: OBX_ACC_RESET, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   // (RULE9) entry at current level
   // no reset here: an unwritten entry is never shown, the used bit guards the top
   always_ff @(posedge core_clk_i) begin
      if (push) begin
         stack_q[s_q.lvl] <= push_addr;
      end
   end

   // register file read address is combinational so reads land same cycle;
   // during a write-back cycle the port carries the write address instead
   assign reg_addr_o = s_q.rwe ? s_q.raddr : instr_reg_i;
   assign reg_we_o = s_q.rwe;
   assign reg_wdata_o = s_q.rdata;

   // secondary page port, same sharing of the address as above
   assign sec_addr_o = s_q.swe ? s_q.saddr : instr_sec_i;
   assign sec_we_o = s_q.swe;
   assign sec_wdata_o = s_q.sdata;

   // core registers straight from the state word
   assign pc_o = s_q.pc;
   assign accumulator_o = s_q.acc;
   assign zero_o = s_q.zero;

   // (RULE9) stack view; the top stays valid after the level wraps to zero,
   // which is why a used bit is kept instead of testing the level
   assign stack_level_o = s_q.lvl;
   assign stack_top_o = s_q.stk_used ? stack_q[s_q.lvl - LW'(1)] : OBX_PC_RESET;

   // handshake output: high through the wait states of trap, jump and call
   assign busy_o = (s_q.st != OBX_ST_EXEC);
endmodule : obx_exec
`default_nettype wire

// ---- hdl/obx_pkg.sv ----
// shared constants and types for the branch / or / secondary page execution block
// Contract
// (RULE1) software trap pushes program counter plus one onto the return stack first
// (RULE2) software trap then loads 0x001 into the program counter; takes three cycles
// (RULE3) or-immediate ors accumulator with constant, updates zero flag, one cycle
// (RULE4) or-register ors accumulator with register; destination bit picks accumulator or register
// (RULE5) store to secondary page copies accumulator to register 5..15, flags untouched
// (RULE6) load from secondary page copies register into accumulator, flags untouched
// (RULE7) long jump loads 11-bit target into program counter, two cycles
// (RULE8) long call pushes program counter plus one, loads target, two cycles
// (RULE9) a push writes the entry at the stack level, then advances the level
// (RULE10) a skip discards the fetched instruction and runs a no-operation instead
// (RULE11) zero flag set when the 8-bit result is zero, else cleared
package obx_pkg;
   localparam int OBX_PC_W = 11;
   localparam int OBX_RADDR_W = 7;
   localparam int OBX_SADDR_W = 4;
   localparam logic [10:0] OBX_TRAP_VECTOR = 11'h001;
   localparam logic [10:0] OBX_PC_RESET = 11'h000;
   localparam logic [7:0] OBX_ACC_RESET = 8'h00;
   localparam logic [3:0] OBX_SEC_LOW = 4'h5;
   localparam logic [3:0] OBX_SEC_HIGH = 4'hF;
   localparam int OBX_TRAP_CYCLES = 3;
   localparam int OBX_BRANCH_CYCLES = 2;
   localparam int OBX_STACK_DEPTH = 8;

   // decoded operation presented by the decode path
   typedef enum logic [2:0] {
      OBX_OP_NONE,
      OBX_OP_TRAP,
      OBX_OP_OR_IMM,
      OBX_OP_OR_REG,
      OBX_OP_STORE_SEC,
      OBX_OP_LOAD_SEC,
      OBX_OP_LJUMP,
      OBX_OP_LONG_CALL_OP
   } obx_op_t;

   typedef enum logic [1:0] {
      OBX_ST_EXEC,
      OBX_ST_WAIT2,
      OBX_ST_WAIT1
   } obx_state_t;

   // zero flag from an 8-bit result
   function automatic logic obx_is_zero(input logic [7:0] v);
      obx_is_zero = (v == 8'h00);
   endfunction : obx_is_zero
endpackage : obx_pkg

// ---- verification/obx_exec_assertions.sv ----
// property checker for the obx execution unit
`timescale 1ns/1ps
`default_nettype none
module obx_exec_assertions
   import obx_pkg::*;
#(parameter int STACK_DEPTH = OBX_STACK_DEPTH) (
   // clock, reset, instruction
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic instr_valid_i,
   input wire obx_op_t instr_op_i,
   input wire logic [7:0] instr_imm_i,
   input wire logic [10:0] instr_target_i,
   input wire logic instr_dest_i,
   input wire logic [3:0] instr_sec_i,
   input wire logic skip_i,
   input wire logic [7:0] reg_rdata_i,
   input wire logic [7:0] sec_rdata_i,
   // watched outputs
   input wire logic reg_we_o,
   input wire logic [7:0] reg_wdata_o,
   input wire logic sec_we_o,
   input wire logic [7:0] sec_wdata_o,
   input wire logic [10:0] pc_o,
   input wire logic [7:0] accumulator_o,
   input wire logic zero_o,
   input wire logic [$clog2(STACK_DEPTH)-1:0] stack_level_o,
   input wire logic [10:0] stack_top_o,
   input wire logic busy_o
);
   // one-hot of the opcode taken this edge, skips excluded
   logic [7:0] hit;
   assign hit = (!busy_o && instr_valid_i && !skip_i) ? 8'(1 << instr_op_i) : 8'h00;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   AST_TRAP_PUSH: assert property (hit[OBX_OP_TRAP]
      |=> stack_top_o == $past(pc_o) + 11'h001) else $error("trap return address wrong");
   AST_TRAP_PC: assert property (hit[OBX_OP_TRAP]
      |=> busy_o ##1 busy_o ##1 (!busy_o && pc_o == OBX_TRAP_VECTOR)) else $error("trap vector");
   AST_OR_IMM: assert property (hit[OBX_OP_OR_IMM]
      |=> accumulator_o == ($past(accumulator_o) | $past(instr_imm_i))
      && zero_o == (accumulator_o == 8'h00)) else $error("or immediate wrong");
   AST_OR_REG: assert property (hit[OBX_OP_OR_REG] && instr_dest_i
      |=> reg_we_o && reg_wdata_o == ($past(accumulator_o) | $past(reg_rdata_i))
      && $stable(accumulator_o)) else $error("or register write wrong");
   AST_STORE: assert property (hit[OBX_OP_STORE_SEC] && instr_sec_i >= OBX_SEC_LOW
      |=> sec_we_o && sec_wdata_o == $past(accumulator_o) && $stable(zero_o)) else $error("store");
   AST_LOAD: assert property (hit[OBX_OP_LOAD_SEC]
      |=> accumulator_o == $past(sec_rdata_i) && $stable(zero_o) && !sec_we_o) else $error("load");
   AST_LJUMP: assert property (hit[OBX_OP_LJUMP]
      |=> busy_o ##1 (!busy_o && pc_o == $past(instr_target_i, 2))) else $error("long jump");
   AST_LONG_CALL_OP: assert property (hit[OBX_OP_LONG_CALL_OP]
      |=> stack_level_o == $past(stack_level_o) + 1'b1 ##1 pc_o == $past(instr_target_i, 2))
      else $error("long call");
   AST_SKIP: assert property (!busy_o && skip_i
      |=> pc_o == $past(pc_o) + 11'h001 && $stable(accumulator_o)) else $error("skip");
   // main scenarios seen
   CVR_TRAP: cover property (hit[OBX_OP_TRAP]);
   CVR_CALL: cover property (hit[OBX_OP_LONG_CALL_OP]);
   CVR_SKIP: cover property (!busy_o && skip_i);
endmodule : obx_exec_assertions
`default_nettype wire

// ---- verification/tb.sv ----
// self-checking bench for the obx execution unit
`timescale 1ns/1ps
`default_nettype none
module tb;
   import obx_pkg::*;
   logic core_clk_i = 1'b0, resetn_i = 1'b0, instr_valid_i = 1'b0, instr_dest_i = 1'b0;
   logic skip_i = 1'b0, reg_we_o, sec_we_o, zero_o, busy_o;
   obx_op_t instr_op_i = OBX_OP_NONE;
   logic [7:0] instr_imm_i = 8'h00, reg_rdata_i, sec_rdata_i;
   logic [7:0] reg_wdata_o, sec_wdata_o, accumulator_o;
   logic [10:0] instr_target_i = 11'h000, pc_o, stack_top_o;
   logic [6:0] instr_reg_i = 7'h00, reg_addr_o;
   logic [3:0] instr_sec_i = 4'h0, sec_addr_o;
   logic [2:0] stack_level_o;
   logic [7:0] sec_mem [16] = '{default: 8'h00};
   int fail_count = 0, checked = 0, mpc = 0, macc = 0, mz = 0, mlvl = 0, n, r, hold = 0, mu = 0;
   int mstk [8];
   int msec [16] = '{default: 0};
   initial begin
      forever #5 core_clk_i = ~core_clk_i;
   end
   // far side: fixed register pattern, secondary page memory written one edge late
   assign reg_rdata_i = {reg_addr_o, 1'b0} ^ 8'h2C;
   assign sec_rdata_i = sec_mem[sec_addr_o];
   always @(posedge core_clk_i) begin
      if (sec_we_o) sec_mem[sec_addr_o] <= sec_wdata_o;
   end
   obx_exec dut_u (.core_clk_i, .resetn_i, .instr_valid_i, .instr_op_i, .instr_imm_i,
      .instr_target_i, .instr_reg_i, .instr_dest_i, .instr_sec_i, .skip_i, .reg_rdata_i,
      .reg_addr_o, .reg_we_o, .reg_wdata_o, .sec_rdata_i, .sec_addr_o, .sec_we_o, .sec_wdata_o,
      .pc_o, .accumulator_o, .zero_o, .stack_level_o, .stack_top_o, .busy_o);
   task chk(input string nm, input logic [10:0] got, input int exp);
      checked++;
      if (got !== 11'(exp)) begin
         $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
         fail_count++;
      end
   endtask : chk
   task summarize;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   // random instruction stream against the integer model
   initial begin
      void'($urandom(32'h19F4));
      repeat (10) @(posedge core_clk_i);
      #1 resetn_i = 1'b1;
      for (int i = 0; i < 500; i++) begin
         // a write is followed by a no-op: the address ports show the write for one cycle
         instr_op_i = obx_op_t'(hold ? 0 : $urandom % 8);
         instr_valid_i = 1'b1;
         skip_i = ($urandom % 8) == 0;
         instr_imm_i = ($urandom % 4 == 0) ? 8'h00 : 8'($urandom);
         instr_target_i = 11'($urandom);
         instr_reg_i = 7'($urandom);
         instr_dest_i = 1'($urandom);
         instr_sec_i = 4'($urandom);
         n = skip_i ? 1 : instr_op_i == OBX_OP_TRAP ? OBX_TRAP_CYCLES
            : instr_op_i >= OBX_OP_LJUMP ? OBX_BRANCH_CYCLES : 1;
         hold = !skip_i && (instr_op_i == OBX_OP_OR_REG && instr_dest_i
            || instr_op_i == OBX_OP_STORE_SEC && instr_sec_i >= 4'h5);
         mpc = (mpc + 1) % 2048;
         if (!skip_i && instr_op_i inside {OBX_OP_TRAP, OBX_OP_LONG_CALL_OP}) begin
            mstk[mlvl] = mpc;
            mlvl = (mlvl + 1) % 8;
            mu = 1;
         end
         if (!skip_i) begin
            case (instr_op_i)
               OBX_OP_TRAP: mpc = 1;
               OBX_OP_LJUMP, OBX_OP_LONG_CALL_OP: mpc = instr_target_i;
               OBX_OP_LOAD_SEC: macc = msec[instr_sec_i];
               OBX_OP_STORE_SEC: if (instr_sec_i >= 4'h5) msec[instr_sec_i] = macc;
               OBX_OP_OR_IMM, OBX_OP_OR_REG: begin
                  // register operand from the far side's pattern, taken from the stimulus
                  r = macc | (instr_op_i == OBX_OP_OR_IMM ? instr_imm_i
                     : 8'({instr_reg_i, 1'b0} ^ 8'h2C));
                  mz = r == 0;
                  if (instr_op_i == OBX_OP_OR_IMM || !instr_dest_i) macc = r;
               end
               default: ;
            endcase
         end
         repeat (n) @(posedge core_clk_i);
         #1;
         chk("pc", pc_o, mpc);
         chk("acc", accumulator_o, macc);
         chk("zero", zero_o, mz);
         chk("level", stack_level_o, mlvl);
         chk("top", stack_top_o, mu ? mstk[(mlvl + 7) % 8] : 0);
         chk("busy", busy_o, 0);
         if (!skip_i && instr_op_i == OBX_OP_STORE_SEC) begin
            r = (instr_sec_i >= OBX_SEC_LOW) ? 256 | macc : 0;
            chk("swr", {sec_we_o, sec_we_o ? sec_wdata_o : 8'h00}, r);
         end
         if (!skip_i && instr_op_i == OBX_OP_OR_REG) begin
            r = instr_dest_i ? 256 | r : 0;
            chk("rwr", {reg_we_o, instr_dest_i ? reg_wdata_o : 8'h00}, r);
         end
      end
      summarize();
   end
endmodule : tb
bind obx_exec obx_exec_assertions #(.STACK_DEPTH(STACK_DEPTH)) chk_u (.core_clk_i, .resetn_i,
   .instr_valid_i, .instr_op_i, .instr_imm_i, .instr_target_i, .instr_dest_i, .instr_sec_i,
   .skip_i, .reg_rdata_i, .sec_rdata_i, .reg_we_o, .reg_wdata_o, .sec_we_o, .sec_wdata_o,
   .pc_o, .accumulator_o, .zero_o, .stack_level_o, .stack_top_o, .busy_o);
`default_nettype wire
